// >>> tb/isss_core_model.sv
// core model: raises one interrupt request and takes the set answer
`timescale 1ns/1ps
module isss_core_model (
    input  wire logic                CLK,
    input  wire isss_pkg::isss_ans_s CORE_ANS,
    output isss_pkg::isss_req_s      CORE_REQ
);
    initial CORE_REQ = '0;
    // answer is registered, so it is taken one edge after the request edge
    task automatic ask(input logic [1:0] l, input logic s, output isss_pkg::isss_ans_s a);
        CORE_REQ <= '{valid: 1'b1, level: l, single: s};
        @(posedge CLK);
        CORE_REQ <= '0;
        @(posedge CLK);
        a = CORE_ANS;
    endtask : ask
endmodule : isss_core_model

// >>> tb/isss_top_sva.sv
// checker: port-level properties of the shadow-set selector
`timescale 1ns/1ps
module isss_chk (
    input wire logic                CLK,
    input wire logic                RST,
    input wire logic                CE,
    input wire logic                HSEL,
    input wire logic                HWRITE,
    input wire logic                HREADY,
    input wire logic                HRESP,
    input wire logic                HREADYOUT,
    input wire logic                DF_IRQ,
    input wire logic                DISP_NONPERSIST,
    input wire logic [7:0]          HADDR,
    input wire logic [1:0]          HTRANS,
    input wire logic [2:0]          HSIZE,
    input wire logic [31:0]         HWDATA,
    input wire logic [31:0]         HRDATA,
    input wire logic [6:0]          DF_VECTOR,
    input wire isss_pkg::isss_req_s CORE_REQ,
    input wire isss_pkg::isss_ans_s CORE_ANS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire acc = CE && HSEL && HREADY && HTRANS == isss_pkg::HTRANS_NONSEQ;
    wire rd  = acc && !HWRITE;
    wire wdp = acc && HWRITE && HSIZE == isss_pkg::HSIZE_WORD && HADDR == isss_pkg::ADDR_DISPCTL;
    sequence s_wdp; wdp ##1 CE; endsequence
    property p_rsv; rd && HADDR == isss_pkg::ADDR_PRISEL |=> HRDATA[3:1] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("unused bits read nonzero");
    property p_unmap; rd && HADDR >= 8'h18 |=> HRDATA == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
    property p_single; CE && CORE_REQ.valid && CORE_REQ.single |=> CORE_ANS.set == 3'h0; endproperty
    a_single: assert property (p_single) else $error("single vector got a set");
    property p_idle; CE && !CORE_REQ.valid |=> CORE_ANS == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_vec; DF_IRQ |-> DF_VECTOR >= 7'h34 && DF_VECTOR <= 7'h39; endproperty
    a_vec: assert property (p_vec) else $error("filter vector out of range");
    property p_dval; s_wdp |=> DISP_NONPERSIST == $past(HWDATA[31]); endproperty
    a_dval: assert property (p_dval) else $error("display type not written");
    property p_dcause; $changed(DISP_NONPERSIST) |-> $past(wdp, 2); endproperty
    a_dcause: assert property (p_dcause) else $error("display type changed alone");
    property p_okay; HREADYOUT && !HRESP; endproperty
    a_okay: assert property (p_okay) else $error("slave not ready or error");
endmodule : isss_chk
bind isss_top isss_chk u_isss_chk (.CLK, .RST, .CE, .HSEL, .HWRITE, .HREADY, .HRESP, .HREADYOUT, .DF_IRQ,
    .DISP_NONPERSIST, .HADDR, .HTRANS, .HSIZE, .HWDATA, .HRDATA, .DF_VECTOR, .CORE_REQ, .CORE_ANS);

// >>> tb/isss_top_tb.sv
// testbench: register access, shadow-set answers and filter interrupts
`timescale 1ns/1ps
module isss_top_tb;
    logic                CLK = 0, RST = 1, HSEL = 0, HWRITE = 0, HREADYOUT, HRESP, DF_IRQ, DISP_NONPERSIST;
    logic                CE = 1;
    logic [7:0]          HADDR = 8'h00;
    logic [1:0]          HTRANS = 2'h0;
    logic [2:0]          HSIZE = 3'h2;
    logic [31:0]         HWDATA = 32'h0, HRDATA, rd;
    logic [5:0]          DF_EVENT = 6'h0;
    logic [6:0]          DF_VECTOR;
    isss_pkg::isss_req_s CORE_REQ;
    isss_pkg::isss_ans_s CORE_ANS, an;
    int                  err_count = 0, comparisons = 0;
    always #50 CLK = ~CLK;
    isss_top u_isss_top (.CLK, .RST, .CE, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .DF_EVENT, .CORE_REQ, .CORE_ANS, .DF_IRQ,
        .DF_VECTOR, .DISP_NONPERSIST);
    isss_core_model u_isss_core_model (.CLK, .CORE_ANS, .CORE_REQ);
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic rdy;
        int n;
        n = 0;
        do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 20);
        if (HREADYOUT !== 1'b1) begin err_count++; conclude; end
    endtask : rdy
    // one single word transfer; read data is taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1; HTRANS <= isss_pkg::HTRANS_NONSEQ; HWRITE <= w; HADDR <= a;
        rdy;
        HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
        rdy;
        rd = HRDATA;
        check(HRESP, 1'b0);
    endtask : bus
    task automatic ask(input logic [1:0] l, input logic s, input logic [3:0] e);
        u_isss_core_model.ask(l, s, an);
        check({28'h0, an}, {28'h0, e});
    endtask : ask
    task automatic t_levels;
        bus(0, isss_pkg::ADDR_PRISEL, 0); check(rd, 32'h0);
        bus(0, 8'h20, 0); check(rd, 32'h0);
        bus(1, isss_pkg::ADDR_INTCTL, 32'h00001000);
        bus(1, isss_pkg::ADDR_PRISEL, 32'hFFFF751F);
        bus(0, isss_pkg::ADDR_PRISEL, 0); check(rd, 32'h00007511);
        ask(3, 0, 4'hF);
        ask(2, 0, 4'hD);
        ask(1, 0, 4'h9);
        ask(0, 0, 4'h8);
        ask(3, 1, 4'h8);
        bus(1, isss_pkg::ADDR_PRISEL, 32'h00009A00);
        ask(3, 0, 4'h8);
        ask(2, 0, 4'h8);
        ask(3, 1, 4'h0);
        bus(1, isss_pkg::ADDR_INTCTL, 32'h0);
        bus(1, isss_pkg::ADDR_PRISEL, 32'h00007771);
        ask(3, 0, 4'h8);
        check(DISP_NONPERSIST, 1'b0);
        bus(1, isss_pkg::ADDR_DISPCTL, 32'h80000000);
        @(posedge CLK);
        check(DISP_NONPERSIST, 1'b1);
        $display("register and set test done");
    endtask : t_levels
    task automatic t_filter;
        bus(1, isss_pkg::ADDR_ENABLE1, 32'h03F00000);
        for (int i = 0; i < 6; i++) begin
            DF_EVENT <= 6'h1 << i;
            repeat (6) @(posedge CLK);
            check(DF_IRQ, 1'b1);
            check(DF_VECTOR, 7'h34 + i);
            bus(0, isss_pkg::ADDR_STATUS, 0); check(rd, 32'h34 + i);
            bus(0, isss_pkg::ADDR_FLAG1, 0); check(rd, 32'h00100000 << i);
            DF_EVENT <= 6'h0;
            bus(1, isss_pkg::ADDR_FLAG1, 0);
            repeat (2) @(posedge CLK);
            check(DF_IRQ, 1'b0);
        end
        $display("filter test done");
    endtask : t_filter
    // with the enable low an event must not even reach the first stage
    task automatic t_freeze;
        CE <= 1'b0;
        DF_EVENT <= 6'h01;
        repeat (6) @(posedge CLK);
        check(DF_IRQ, 1'b0);
        CE <= 1'b1;
        repeat (6) @(posedge CLK);
        check(DF_IRQ, 1'b1);
        check(DF_VECTOR, 7'h34);
        DF_EVENT <= 6'h00;
        bus(1, isss_pkg::ADDR_FLAG1, 0);
        $display("clock enable test done");
    endtask : t_freeze
    initial begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        t_levels;
        t_filter;
        t_freeze;
        conclude;
    end
endmodule : isss_top_tb

// >>> verilog/isss_level_decode.sv
// one priority level's field decoded to a shadow set number
`timescale 1ns/1ps
module isss_level_decode (
    input  wire logic [3:0] field,
    output logic      [2:0] set
);
    // reserved codes fall back to set 0
    assign set = field[3] ? isss_pkg::NO_SET : field[2:0];
endmodule : isss_level_decode

// >>> verilog/isss_pkg.sv
// package: register map, field layout and types for the shadow-set selector
package isss_pkg;
    localparam logic [7:0]  ADDR_PRISEL      = 8'h00;
    localparam logic [7:0]  ADDR_INTCTL      = 8'h04;
    localparam logic [7:0]  ADDR_DISPCTL     = 8'h08;
    localparam logic [7:0]  ADDR_FLAG1       = 8'h0C;
    localparam logic [7:0]  ADDR_ENABLE1     = 8'h10;
    localparam logic [7:0]  ADDR_STATUS      = 8'h14;
    localparam int          L3_LSB           = 12;
    localparam int          L2_LSB           = 8;
    localparam int          L1_LSB           = 4;
    localparam int          SV_BIT           = 0;
    localparam int          MULTI_VECTOR_MODE_BIT         = 12;
    localparam int          DISP_TYPE_BIT    = 31;
    localparam int          DF_FLAG_LSB      = 20;
    localparam int          DF_COUNT         = 6;
    localparam logic [6:0]  DF_VECTOR_BASE   = 7'h34;
    localparam logic [31:0] PRISEL_MASK      = 32'h0000FFF1;
    localparam logic [31:0] INTCTL_MASK      = 32'h00001000;
    localparam logic [31:0] DISPCTL_MASK     = 32'h80000000;
    localparam logic [31:0] DF_MASK          = 32'h03F00000;
    localparam logic [31:0] RESET_WORD       = 32'h00000000;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [2:0]  HSIZE_WORD       = 3'h2;
    localparam logic [2:0]  NO_SET           = 3'h0;
    localparam logic [1:0]  LEVEL1           = 2'h1;
    localparam logic [1:0]  LEVEL2           = 2'h2;
    localparam logic [1:0]  LEVEL3           = 2'h3;

    typedef struct packed {
        logic       valid;
        logic [1:0] level;
        logic       single;
    } isss_req_s;

    typedef struct packed {
        logic       use_set;
        logic [2:0] set;
    } isss_ans_s;
endpackage : isss_pkg

// >>> verilog/isss_top.sv
// top: AHB-Lite registers, shadow-set choice and filter interrupt flags
// What this block does
// - bits 15-12 choose level 3 set
// - bits 11-8 choose level 2 set
// - bits 7-4 choose level 1 set
// - reserved top-bit codes give set 0
// - bit 0 adds shadow set to single vector
// - level fields ignored when multi-vector off
// - bits 3-1 read zero
// - display irq persistent until bit 31 set
// - filter sources 1-6 use vectors 52-57, bits 20-25
`timescale 1ns/1ps
module isss_top (
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic                CE,
    input  wire logic                HSEL,
    input  wire logic [7:0]          HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic      [31:0]         HRDATA,
    output logic                     HREADYOUT,
    output logic                     HRESP,
    input  wire logic [5:0]          DF_EVENT,
    input  wire isss_pkg::isss_req_s CORE_REQ,
    output isss_pkg::isss_ans_s      CORE_ANS,
    output logic                     DF_IRQ,
    output logic      [6:0]          DF_VECTOR,
    output logic                     DISP_NONPERSIST
);
    logic [31:0]         prisel_q;
    logic [31:0]         prisel_d;
    logic [31:0]         intctl_q;
    logic [31:0]         intctl_d;
    logic [31:0]         disp_q;
    logic [31:0]         disp_d;
    logic [31:0]         flag_q;
    logic [31:0]         flag_d;
    logic [31:0]         en_q;
    logic [31:0]         en_d;
    logic                wr_pend_q;
    logic [7:0]          wr_addr_q;
    logic [31:0]         rdata_q;
    isss_pkg::isss_ans_s ans_q;
    logic                irq_q;
    logic [6:0]          vec_q;
    logic [5:0]          ev_s1_q;
    logic [5:0]          ev_s2_q;
    logic [5:0]          ev_s3_q;

    wire         acc      = HSEL & HREADY & HTRANS == isss_pkg::HTRANS_NONSEQ;
    wire         rd_acc   = acc & ~HWRITE;
    wire         wr_acc   = acc & HWRITE & HSIZE == isss_pkg::HSIZE_WORD;
    wire         w_pri    = wr_pend_q & wr_addr_q == isss_pkg::ADDR_PRISEL;
    wire         w_int    = wr_pend_q & wr_addr_q == isss_pkg::ADDR_INTCTL;
    wire         w_disp   = wr_pend_q & wr_addr_q == isss_pkg::ADDR_DISPCTL;
    wire         w_flag   = wr_pend_q & wr_addr_q == isss_pkg::ADDR_FLAG1;
    wire         w_en     = wr_pend_q & wr_addr_q == isss_pkg::ADDR_ENABLE1;
    wire [5:0]   ev_rise  = ev_s2_q & ~ev_s3_q;
    wire [31:0]  ev_word  = 32'(ev_rise) << isss_pkg::DF_FLAG_LSB;
    wire         multi_vector_mode     = intctl_q[isss_pkg::MULTI_VECTOR_MODE_BIT];
    wire [2:0]   set3;
    wire [2:0]   set2;
    wire [2:0]   set1;
    wire [31:0]  pend     = flag_q & en_q & isss_pkg::DF_MASK;

    isss_level_decode u_l3 (.field(prisel_q[isss_pkg::L3_LSB +: 4]), .set(set3));
    isss_level_decode u_l2 (.field(prisel_q[isss_pkg::L2_LSB +: 4]), .set(set2));
    isss_level_decode u_l1 (.field(prisel_q[isss_pkg::L1_LSB +: 4]), .set(set1));

    // level 0 has no field here and takes set 0
    wire       lvl3    = CORE_REQ.level == isss_pkg::LEVEL3;
    wire       lvl2    = CORE_REQ.level == isss_pkg::LEVEL2;
    wire       lvl1    = CORE_REQ.level == isss_pkg::LEVEL1;
    wire [2:0] lvl_set = lvl3 ? set3 :
                         lvl2 ? set2 :
                         lvl1 ? set1 : isss_pkg::NO_SET;
    wire       sv_en   = prisel_q[isss_pkg::SV_BIT];
    wire       multi   = multi_vector_mode & ~CORE_REQ.single;
    wire isss_pkg::isss_ans_s ans_d = ~CORE_REQ.valid ? '0 :
                         multi ? {1'b1, lvl_set} : {sv_en, isss_pkg::NO_SET};

    // lowest pending filter source wins the vector
    logic [6:0] vec_d;
    always_comb begin
        vec_d = vec_q;
        for (int i = isss_pkg::DF_COUNT - 1; i >= 0; i--) begin
            if (pend[isss_pkg::DF_FLAG_LSB + i]) begin
                vec_d = isss_pkg::DF_VECTOR_BASE + 7'(i);
            end
        end
    end

    // masks drop reserved bits so they always read zero
    assign prisel_d = w_pri  ? HWDATA & isss_pkg::PRISEL_MASK : prisel_q;
    assign intctl_d = w_int  ? HWDATA & isss_pkg::INTCTL_MASK : intctl_q;
    assign disp_d   = w_disp ? HWDATA & isss_pkg::DISPCTL_MASK : disp_q;
    assign en_d     = w_en   ? HWDATA & isss_pkg::DF_MASK : en_q;
    // a new event wins over a software clear in the same cycle
    assign flag_d   = ((w_flag ? HWDATA : flag_q) | ev_word) & isss_pkg::DF_MASK;

    wire        r_pri    = HADDR == isss_pkg::ADDR_PRISEL;
    wire        r_int    = HADDR == isss_pkg::ADDR_INTCTL;
    wire        r_disp   = HADDR == isss_pkg::ADDR_DISPCTL;
    wire        r_flag   = HADDR == isss_pkg::ADDR_FLAG1;
    wire        r_en     = HADDR == isss_pkg::ADDR_ENABLE1;
    wire        r_stat   = HADDR == isss_pkg::ADDR_STATUS;
    // unmapped offsets read as zero rather than aliasing a register
    wire [31:0] rd_mux   = r_pri  ? prisel_q :
                           r_int  ? intctl_q :
                           r_disp ? disp_q :
                           r_flag ? flag_q :
                           r_en   ? en_q :
                           r_stat ? 32'(vec_q) :
                                    isss_pkg::RESET_WORD;

    always_ff @(posedge CLK) begin
        if (RST) begin
            prisel_q <= isss_pkg::RESET_WORD;
        end else if (CE) begin
            prisel_q <= prisel_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            intctl_q <= isss_pkg::RESET_WORD;
        end else if (CE) begin
            intctl_q <= intctl_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            disp_q <= isss_pkg::RESET_WORD;
        end else if (CE) begin
            disp_q <= disp_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            flag_q <= isss_pkg::RESET_WORD;
        end else if (CE) begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            en_q <= isss_pkg::RESET_WORD;
        end else if (CE) begin
            en_q <= en_d;
        end
    end

    // write data comes a cycle after its address, so the address is kept
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (CE) begin
            wr_pend_q <= wr_acc;
            wr_addr_q <= HADDR;
        end
    end

    // read data stands in its data phase only and is zero otherwise
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_q <= isss_pkg::RESET_WORD;
        end else if (CE) begin
            rdata_q <= rd_acc ? rd_mux : isss_pkg::RESET_WORD;
        end
    end

    // event pins are asynchronous: two stages, then an edge stage
    always_ff @(posedge CLK) begin
        if (RST) begin
            ev_s1_q <= 6'h00;
            ev_s2_q <= 6'h00;
            ev_s3_q <= 6'h00;
        end else if (CE) begin
            ev_s1_q <= DF_EVENT;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
        end
    end

    // registered answer: the core takes it one cycle after its request
    always_ff @(posedge CLK) begin
        if (RST) begin
            ans_q <= '0;
        end else if (CE) begin
            ans_q <= ans_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_q <= 1'b0;
            vec_q <= 7'h00;
        end else if (CE) begin
            irq_q <= |pend;
            vec_q <= vec_d;
        end
    end

    assign HRDATA          = rdata_q;
    // no wait states: every register answers in its first data phase
    assign HREADYOUT       = 1'b1;
    assign HRESP           = 1'b0;
    assign CORE_ANS        = ans_q;
    assign DF_IRQ          = irq_q;
    assign DF_VECTOR       = vec_q;
    assign DISP_NONPERSIST = disp_q[isss_pkg::DISP_TYPE_BIT];
endmodule : isss_top
